// [rtl/dma_sched_regs.vh]
// constants for the dma/user process scheduler and bus request queue
// assumes inclusion by bare name from rtl/ design files
`ifndef DMA_SCHED_REGS_VH
`define DMA_SCHED_REGS_VH
`define CTX_USER 3'h4
`define CTX_W 3
`define RATIO_MAX_4TO1 3'h4
`define RATIO_MAX_1TO1 3'h1
`define THROTTLE_RESET 1'h0
`define QUEUE_DEPTH 2'h3
`define QUEUE_USER_SLOTS 2'h2
`define QUEUE_DMA_SLOTS 2'h1
`define CNT_W 16
`endif

// [rtl/channel_priority_arbiter.v]
// fixed-priority arbiter over the four channel request inputs
// assumes requests already synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module channel_priority_arbiter (
  // request vector
  input wire [3:0] req,
  // one-hot winner and its index
  output reg [3:0] grant,
  output reg [1:0] grant_idx,
  output reg any
);
  // lowest index wins
  always @*
  begin
    grant = 4'h0;
    grant_idx = 2'h0;
    any = |req;
    if (req[0])
    begin
      grant = 4'h1;
      grant_idx = 2'h0;
    end
    else if (req[1])
    begin
      grant = 4'h2;
      grant_idx = 2'h1;
    end
    else if (req[2])
    begin
      grant = 4'h4;
      grant_idx = 2'h2;
    end
    else if (req[3])
    begin
      grant = 4'h8;
      grant_idx = 2'h3;
    end
  end
endmodule // channel_priority_arbiter
`default_nettype wire

// [rtl/dma_user_process_scheduler.v]
// dma/user process scheduler with bus request queue arbitration
// assumes synchronous inputs, one ref_clk domain, srst synchronous high
// ready outputs are combinational; every other output is registered
`include "dma_sched_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module dma_user_process_scheduler (
  // clock, reset, enable
  input wire ref_clk,
  input wire srst,
  input wire clk_en,
  // configuration
  input wire throttle_select_bit,
  input wire [3:0] channel_setup,
  input wire [3:0] channel_pending,
  // peripheral handshake
  input wire [3:0] channel_request_inputs,
  output reg [3:0] channel_acknowledge_outputs,
  // process context
  output reg [2:0] active_context,
  output reg dma_event,
  // request entry
  input wire user_req_valid,
  output wire user_req_ready,
  input wire dma_req_valid,
  output wire dma_req_ready,
  // bus controller side
  output reg bus_issue,
  output reg bus_is_dma,
  input wire bus_done,
  // measurement
  output reg [15:0] clocks_per_request,
  output reg [15:0] request_latency
);
  reg throttle;
  reg [2:0] ratio_cnt;
  reg [1:0] user_cnt;
  reg [1:0] dma_cnt;
  reg last_dma;
  reg busy;
  reg [1:0] ack_ch;
  reg [15:0] gap_cnt;
  reg [15:0] lat_cnt [0:3];
  wire [3:0] win;
  wire [1:0] win_idx;
  wire win_any;
  wire split;
  wire [1:0] total;
  wire [2:0] ratio_max;
  wire take_user;
  wire take_dma;
  wire pick_dma;
  wire [3:0] pend_work;
  wire room;
  integer i;

  function [15:0] inc_sat;
    input [15:0] v;
    begin
      inc_sat = (v == 16'hffff) ? v : v + 16'h0001;
    end
  endfunction

  // lowest set bit of a four-bit vector; bit 0 ranks highest
  function [1:0] low_idx;
    input [3:0] v;
    begin
      if (v[0])
        low_idx = 2'h0;
      else if (v[1])
        low_idx = 2'h1;
      else if (v[2])
        low_idx = 2'h2;
      else
        low_idx = 2'h3;
    end
  endfunction

  // requests from channels that are set up arbitrate by fixed priority
  channel_priority_arbiter u_arb (
    .req(channel_request_inputs & channel_setup),
    .grant(win),
    .grant_idx(win_idx),
    .any(win_any)
  );

  assign split = |channel_setup;
  assign total = user_cnt + dma_cnt;
  // undivided queue lets one process use all three slots
  // channels set up with work queued, whether or not they also request
  assign pend_work = channel_setup & channel_pending;
  // ready drops while frozen, otherwise a requester would lose its entry
  assign room = clk_en && (total < `QUEUE_DEPTH);
  assign user_req_ready = room && (!split || user_cnt < `QUEUE_USER_SLOTS);
  assign dma_req_ready = room && (!split || dma_cnt < `QUEUE_DMA_SLOTS);
  assign take_user = user_req_valid && user_req_ready;
  assign take_dma = dma_req_valid && dma_req_ready;
  assign ratio_max = throttle ? `RATIO_MAX_1TO1 : `RATIO_MAX_4TO1;
  // alternate when both hold entries, else serve whoever has one
  assign pick_dma = (dma_cnt != 2'h0) && ((user_cnt == 2'h0) || !last_dma);

  // context switching: one register update per edge, no idle cycle
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      throttle <= `THROTTLE_RESET;
      active_context <= `CTX_USER;
      ratio_cnt <= 3'h0;
      dma_event <= 1'b0;
    end
    else if (clk_en)
    begin
      throttle <= throttle_select_bit;
      dma_event <= win_any || (|pend_work);
      if (active_context == `CTX_USER)
      begin
        ratio_cnt <= 3'h0;
        // a pending-only event still enters that channel's own context
        if (dma_event)
          active_context <= {1'b0, win_any ? win_idx : low_idx(pend_work)};
      end
      else if (ratio_cnt + 3'h1 >= ratio_max || !dma_event)
      begin
        active_context <= `CTX_USER;
        ratio_cnt <= 3'h0;
      end
      else
        ratio_cnt <= ratio_cnt + 3'h1;
    end
  end

  // queue occupancy and issue; one transaction in flight at a time
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      user_cnt <= 2'h0;
      dma_cnt <= 2'h0;
      last_dma <= 1'b0;
      busy <= 1'b0;
      bus_issue <= 1'b0;
      bus_is_dma <= 1'b0;
      ack_ch <= 2'h0;
      channel_acknowledge_outputs <= 4'h0;
    end
    else if (clk_en)
    begin
      bus_issue <= 1'b0;
      if (!busy && (user_cnt != 2'h0 || dma_cnt != 2'h0))
      begin
        busy <= 1'b1;
        bus_issue <= 1'b1;
        bus_is_dma <= pick_dma;
        last_dma <= pick_dma;
        user_cnt <= user_cnt + {1'b0, take_user} - {1'b0, !pick_dma};
        dma_cnt <= dma_cnt + {1'b0, take_dma} - {1'b0, pick_dma};
        if (pick_dma && win_any)
        begin
          ack_ch <= win_idx;
          channel_acknowledge_outputs <= win;
        end
      end
      else
      begin
        user_cnt <= user_cnt + {1'b0, take_user};
        dma_cnt <= dma_cnt + {1'b0, take_dma};
        if (busy && bus_done)
        begin
          busy <= 1'b0;
          channel_acknowledge_outputs <= 4'h0;
        end
      end
    end
  end

  // throughput and latency counters in processor clocks
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      gap_cnt <= 16'h0000;
      clocks_per_request <= 16'h0000;
      request_latency <= 16'h0000;
      for (i = 0; i < 4; i = i + 1)
        lat_cnt[i] <= 16'h0000;
    end
    else if (clk_en)
    begin
      // restart the gap on each new acknowledge rising edge
      if (bus_issue && bus_is_dma && channel_acknowledge_outputs != 4'h0)
      begin
        clocks_per_request <= gap_cnt;
        gap_cnt <= 16'h0001;
        // keep the worst case seen since reset
        if (lat_cnt[ack_ch] > request_latency)
          request_latency <= lat_cnt[ack_ch];
      end
      else
        gap_cnt <= inc_sat(gap_cnt);
      for (i = 0; i < 4; i = i + 1)
        if (!channel_request_inputs[i] || channel_acknowledge_outputs[i])
          lat_cnt[i] <= 16'h0000;
        else
          lat_cnt[i] <= inc_sat(lat_cnt[i]);
    end
  end
endmodule // dma_user_process_scheduler
`default_nettype wire

// [dv/sched_props.sv]
// port checker for the dma/user process scheduler
// assumes one ref_clk domain, srst synchronous high
`timescale 1ns/1ps
`default_nettype none
module sched_props (
  // clock, reset
  input wire logic ref_clk,
  input wire logic srst,
  // watched ports
  input wire logic throttle_select_bit,
  input wire logic [3:0] channel_acknowledge_outputs,
  input wire logic [2:0] active_context,
  input wire logic dma_event,
  // bus controller side
  input wire logic bus_issue,
  input wire logic bus_is_dma,
  input wire logic bus_done
);
  // short aliases keep the properties readable
  wire [3:0] ak = channel_acknowledge_outputs;
  wire dc = active_context != 3'h4; // core in a dma context
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_rst; $fell(srst) |-> !dc && ak == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_oh; $onehot0(ak); endproperty
  a_oh: assert property (p_oh) else $error("ack not one-hot");
  property p_ev; !dc ##1 dc |-> $past(dma_event); endproperty
  a_ev: assert property (p_ev) else $error("switch without event");
  property p_r4; dc [*4] |=> !dc; endproperty
  a_r4: assert property (p_r4) else $error("dma over 4 cycles");
  property p_r1; throttle_select_bit [*8] ##0 dc |=> !dc; endproperty
  a_r1: assert property (p_r1) else $error("dma over 1 cycle");
  property p_ak; bus_issue && ak != 4'h0 |-> bus_is_dma; endproperty
  a_ak: assert property (p_ak) else $error("ack on user issue");
  property p_hold; ak != 4'h0 && !bus_done |=> $stable(ak); endproperty
  a_hold: assert property (p_hold) else $error("ack dropped early");
  property p_kind; $changed(bus_is_dma) |-> bus_issue; endproperty
  a_kind: assert property (p_kind) else $error("kind moved alone");
endmodule // sched_props
bind dma_user_process_scheduler sched_props u_props (.ref_clk, .srst, .throttle_select_bit,
  .channel_acknowledge_outputs, .active_context, .dma_event, .bus_issue, .bus_is_dma, .bus_done);
`default_nettype wire

// [dv/bus_model.sv]
// bus controller stand-in: a done pulse three edges after each issue
// assumes issue is one cycle wide; hold stalls the answer
`timescale 1ns/1ps
`default_nettype none
module bus_model (
  // clock, reset
  input wire logic ref_clk,
  input wire logic srst,
  // transaction handshake
  input wire logic bus_issue,
  input wire logic hold,
  output logic bus_done
);
  logic [1:0] left;
  // countdown; a stall freezes it on the last step
  always @(posedge ref_clk)
  begin
    bus_done <= !srst && left == 2'h1 && !hold;
    if (srst || bus_issue)
      left <= srst ? 2'h0 : 2'h3;
    else if (left != 2'h0 && !(left == 2'h1 && hold))
      left <= left - 2'h1;
  end
endmodule // bus_model
`default_nettype wire

// [dv/tb_top.sv]
// bench for the dma/user process scheduler
// assumes bus_model as bus controller, checker bound elsewhere
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'h0, srst = 1'h1, thr = 1'h0, uv = 1'h0, dv = 1'h0, hold = 1'h0;
  logic [3:0] setup = 4'h0, pend = 4'h0, req = 4'h0, ack;
  logic [2:0] ctx;
  logic ev, ur, dr, issue, isdma, done;
  logic [15:0] cpr, lat;
  int failures = 0, check_count = 0, n;
  // setup, requests, expected acknowledge
  logic [11:0] r [6] = '{12'hff1, 12'hfe2, 12'hfc4, 12'hf88, 12'hef2, 12'h6a2};
  dma_user_process_scheduler uut (.ref_clk(clk), .srst(srst), .clk_en(1'h1), .throttle_select_bit(thr),
    .channel_setup(setup), .channel_pending(pend), .channel_request_inputs(req), .channel_acknowledge_outputs(ack),
    .active_context(ctx), .dma_event(ev), .user_req_valid(uv), .user_req_ready(ur), .dma_req_valid(dv),
    .dma_req_ready(dr), .bus_issue(issue), .bus_is_dma(isdma), .bus_done(done), .clocks_per_request(cpr),
    .request_latency(lat));
  bus_model bm (.ref_clk(clk), .srst(srst), .bus_issue(issue), .hold(hold), .bus_done(done));
  // 25 mhz clock
  initial
  begin
    forever #20 clk = ~clk;
  end
  task automatic report_and_stop;
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // counted comparison
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // counted comparison of the cycle measurements
  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait: 0 user ready, 1 dma ready at edges, 2 issue mid-cycle
  task automatic wt(input int s);
    n = 0;
    do
    begin
      if (s == 2)
        @(negedge clk);
      else
        @(posedge clk);
      n++;
    end
    while ((s == 2 ? issue : s == 1 ? dr : ur) !== 1'h1 && n < 60);
    if ((s == 2 ? issue : s == 1 ? dr : ur) !== 1'h1)
    begin
      failures++;
      report_and_stop;
    end
  endtask
  // offer an entry, held until taken
  task automatic push(input int s);
    @(posedge clk);
    {dv, uv} <= s ? 2'h2 : 2'h1;
    wt(s);
    {dv, uv} <= 2'h0;
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    @(negedge clk);
    chk({1'h0, ctx}, 4'h4);
    foreach (r[k])
    begin
      @(posedge clk);
      {setup, req} <= r[k][11:4];
      push(1);
      wt(2);
      chk(ack, r[k][3:0]);
      chk({3'h0, isdma}, 4'h1);
      repeat (6) @(posedge clk);
    end
    // rows are ten cycles apart; channel 3 waited from row 0 to row 3
    chk_cnt(cpr, 16'h000a);
    chk_cnt(lat, 16'h0021);
    // 1:1 throttle, channel 0 set up with work, bus stalled
    {thr, setup, pend, req, hold} <= 14'h2221;
    push(0);
    push(0);
    push(1);
    hold <= 1'h0;
    wt(2);
    chk({3'h0, isdma}, 4'h1);
    wt(2);
    chk({3'h0, isdma}, 4'h0);
    n = 0;
    repeat (20)
    begin
      @(negedge clk);
      n += (ctx != 3'h4);
    end
    chk({3'h0, n > 0 && n < 11}, 4'h1);
    // no channel set up, bus stalled: one process fills all three slots
    @(posedge clk);
    {thr, setup, pend, hold} <= 10'h001;
    repeat (4)
      push(0);
    @(negedge clk);
    chk({2'h0, ur, dr}, 4'h0);
    @(posedge clk);
    hold <= 1'h0;
    repeat (30) @(posedge clk);
    // channel set up: user stops at two entries, the dma slot stays open
    {setup, hold} <= 5'h03;
    repeat (3)
      push(0);
    @(negedge clk);
    chk({2'h0, ur, dr}, 4'h1);
    push(1);
    @(negedge clk);
    chk({2'h0, ur, dr}, 4'h0);
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
